// ### verilog/asrp_pkg.sv
// Overview of operation
// - Each conversion result is a 12-bit unsigned code.
// - Host link is active-low select, host serial clock, serial result line.
// - Conversion timed by internal clock, not serial clock, lasting 3.5 us.
// - Block powers down by itself between active cycles.
// - Output stays high impedance until select falls or frame sync rises while select low.
// - Result shifts out most significant bit first.
// - Frame sync high at select fall: MSB driven, valid first falling clock.
// - Frame sync low at select fall: both controls used, MSB still driven.
// - While select low, each frame sync rise restarts the frame with the MSB of the next buffered result.
// - Bits valid at falling clock edges; host samples on those edges.
// - Frame is 16 bits: result in upper twelve, four ignored trailing bits.
// - Straight unipolar binary, zero code at ground, all ones at full scale.
// - Bits change on rising clock; output released after sixteenth clock.
package asrp_pkg;
	localparam int          RES_W     = 12;
	localparam int          FRAME_W   = 16;
	localparam int          CNT_W     = 5;
	localparam int          CLK_HZ    = 25000000;
	localparam real         CONV_US   = 3.5;
	localparam int          CONV_CYC  = (CONV_US * CLK_HZ / 1000000.0 < 1.0) ? 1 : int'(CONV_US * CLK_HZ / 1000000.0 + 0.499);
	localparam int          FIFO_D    = 4;
	localparam logic [3:0]  PAD_BITS  = 4'h0;
	localparam logic [4:0]  CNT_ZERO  = 5'h00;
	localparam logic [4:0]  CNT_FULL  = 5'h10;
	localparam logic [11:0] CODE_ZERO = 12'h000;
	typedef enum logic [1:0] {ASRP_SLEEP, ASRP_CONV, ASRP_READY} asrp_conv_t;
endpackage : asrp_pkg

// ### verilog/asrp_fifo_if.sv
`timescale 1ns/1ps
interface asrp_fifo_if #(parameter int W = 12);
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] in_data;
	logic         out_valid;
	logic         out_ready;
	logic [W-1:0] out_data;
	modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : asrp_fifo_if

// ### verilog/asrp_fifo.sv
`timescale 1ns/1ps
module asrp_fifo #(
	parameter int W = 12,
	parameter int D = 4
) (
	// Clock and reset
	input  wire logic   clk,
	input  wire logic   srst,
	// Stream
	asrp_fifo_if.fifo   f
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_q [D];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0]   cnt_q, cnt_d;
	logic          push, pop;

	assign f.in_ready  = (cnt_q != (AW+1)'(D));
	assign f.out_valid = (cnt_q != '0);
	assign f.out_data  = mem_q[rd_q];
	assign push        = f.in_valid && f.in_ready;
	assign pop         = f.out_valid && f.out_ready;

	always_comb begin
		wr_d  = push ? ((wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1) : wr_q;
		rd_d  = pop ? ((rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1) : rd_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
		if (push) begin
			mem_q[wr_q] <= f.in_data;
		end
	end
endmodule : asrp_fifo

// ### verilog/asrp_top.sv
`timescale 1ns/1ps
module asrp_top
	import asrp_pkg::*;
#(
	parameter int RW = RES_W,
	parameter int CC = CONV_CYC
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          srst,
	// Converter core
	input  wire logic          conv_valid,
	input  wire logic [RW-1:0] conv_code,
	output logic               conv_ready,
	output logic               powered_down,
	// Host link
	input  wire logic          cs_n,
	input  wire logic          sclk,
	input  wire logic          frame_sync_in,
	output logic               serial_result_out,
	output logic               serial_result_oe
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [2:0] cs_s_q, sk_s_q, fs_s_q;
	logic       cs_q, sk_q, fs_q;
	logic       cs_d, sk_d, fs_d;

	always_comb begin
		cs_d = cs_q;
		sk_d = sk_q;
		fs_d = fs_q;
		// A new level counts once the last two stages agree
		if (cs_s_q[2] == cs_s_q[1]) begin
			cs_d = cs_s_q[1];
		end
		if (sk_s_q[2] == sk_s_q[1]) begin
			sk_d = sk_s_q[1];
		end
		if (fs_s_q[2] == fs_s_q[1]) begin
			fs_d = fs_s_q[1];
		end
	end

	// Sampling stages
	always_ff @(posedge clk) begin
		if (srst) begin
			cs_s_q <= 3'h7;
			sk_s_q <= 3'h0;
			fs_s_q <= 3'h7;
		end else begin
			cs_s_q <= {cs_s_q[1:0], cs_n};
			sk_s_q <= {sk_s_q[1:0], sclk};
			fs_s_q <= {fs_s_q[1:0], frame_sync_in};
		end
	end

	// Filtered levels
	always_ff @(posedge clk) begin
		if (srst) begin
			cs_q   <= 1'b1;
			sk_q   <= 1'b0;
			fs_q   <= 1'b1;
		end else begin
			cs_q   <= cs_d;
			sk_q   <= sk_d;
			fs_q   <= fs_d;
		end
	end

	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	logic cs_fall, fs_rise, sk_rise, sk_fall, start;

	always_comb begin
		cs_fall = cs_q && !cs_d;
		fs_rise = !fs_q && fs_d;
		sk_rise = !sk_q && sk_d;
		sk_fall = sk_q && !sk_d;
		// Select fall with frame sync high or low, or frame sync rise under select
		start   = cs_fall || (fs_rise && !cs_q);
	end

	// ----------------------------------------
	// Result buffer
	// ----------------------------------------
	asrp_fifo_if #(.W(RW)) fq ();
	asrp_fifo #(.W(RW), .D(FIFO_D)) u_fifo (
		.clk  (clk),
		.srst (srst),
		.f    (fq)
	);

	// Stream into the buffer
	assign fq.in_valid  = (st_q == ASRP_READY);
	assign fq.in_data   = cv_q;

	// ----------------------------------------
	// Conversion timer and power down
	// ----------------------------------------
	asrp_conv_t     st_q, st_d;
	logic [15:0]    tm_q, tm_d;
	logic [RW-1:0]  cv_q, cv_d;

	// Idle converter takes a sample; asleep when nothing waits
	always_comb begin
		conv_ready   = (st_q == ASRP_SLEEP);
		powered_down = (st_q == ASRP_SLEEP) && !fq.out_valid;
	end

	always_comb begin
		st_d = st_q;
		tm_d = tm_q;
		cv_d = cv_q;
		case (st_q)
			ASRP_SLEEP: begin
				if (conv_valid) begin
					st_d = ASRP_CONV;
					tm_d = 16'(CC - 1);
					cv_d = conv_code;
				end
			end
			ASRP_CONV: begin
				// Internal clock counts, serial clock not involved
				if (tm_q == '0) begin
					st_d = ASRP_READY;
				end else begin
					tm_d = tm_q - 1'b1;
				end
			end
			ASRP_READY: begin
				if (fq.in_ready) begin
					st_d = ASRP_SLEEP;
				end
			end
			default: begin
				st_d = ASRP_SLEEP;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_q <= ASRP_SLEEP;
			tm_q <= '0;
			cv_q <= CODE_ZERO;
		end else begin
			st_q <= st_d;
			tm_q <= tm_d;
			cv_q <= cv_d;
		end
	end

	// ----------------------------------------
	// Serial shifter
	// ----------------------------------------
	logic [FRAME_W-1:0] sh_q, sh_d;
	logic [CNT_W-1:0]   bc_q, bc_d;
	logic               oe_q, oe_d;
	logic               act_q, act_d;
	logic [CNT_W-1:0]   bc_nx;
	logic               last_bit;

	// Each frame start takes the oldest buffered result
	assign fq.out_ready      = start;

	always_comb begin
		sh_d     = sh_q;
		bc_d     = bc_q;
		oe_d     = oe_q;
		act_d    = act_q;
		bc_nx    = bc_q + 1'b1;
		last_bit = (bc_nx == CNT_FULL);
		if (start) begin
			// Oldest buffered result, or zero code when none is buffered
			sh_d  = {(fq.out_valid ? fq.out_data : CODE_ZERO), PAD_BITS};
			bc_d  = CNT_ZERO;
			oe_d  = 1'b1;
			act_d = 1'b1;
		end else if (cs_q) begin
			oe_d  = 1'b0;
			act_d = 1'b0;
		end else if (act_q && sk_fall) begin
			// Host samples here; count the bit
			bc_d = bc_nx;
			if (last_bit) begin
				act_d = 1'b0;
				oe_d  = 1'b0;
			end
		end else if (act_q && sk_rise) begin
			// First rise of a frame keeps the MSB
			if (bc_q != CNT_ZERO) begin
				sh_d = {sh_q[FRAME_W-2:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sh_q  <= '0;
			bc_q  <= CNT_ZERO;
			oe_q  <= 1'b0;
			act_q <= 1'b0;
		end else begin
			sh_q  <= sh_d;
			bc_q  <= bc_d;
			oe_q  <= oe_d;
			act_q <= act_d;
		end
	end

	// ----------------------------------------
	// Output stage
	// ----------------------------------------
	assign serial_result_out = sh_q[FRAME_W-1];
	assign serial_result_oe  = oe_q;
endmodule : asrp_top

// ### tb/asrp_props.sv
`timescale 1ns/1ps
// -
// Link checks
// -
module asrp_props (
	// Watched ports
	input wire logic clk,
	input wire logic srst,
	input wire logic conv_valid,
	input wire logic conv_ready,
	input wire logic powered_down,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic frame_sync_in,
	input wire logic serial_result_out,
	input wire logic serial_result_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic       sck_q;
	logic [4:0] nf_q, nf_d;
	always_comb nf_d = serial_result_oe ? nf_q + 5'(sck_q & !sclk) : 5'h00;
	always_ff @(posedge clk) begin
		sck_q <= sclk;
		nf_q  <= nf_d;
	end
	sequence s_sel; $fell(cs_n) ##1 (!cs_n) [*2]; endsequence
	sequence s_fsr; !cs_n && $rose(frame_sync_in); endsequence
	property p_rel; $fell(srst) |-> !serial_result_oe && powered_down; endproperty
	a_rel: assert property (p_rel) else $error("reset");
	property p_sel; s_sel |-> ##[0:5] serial_result_oe; endproperty
	a_sel: assert property (p_sel) else $error("no drive");
	property p_fsr; s_fsr |-> ##[1:7] serial_result_oe; endproperty
	a_fsr: assert property (p_fsr) else $error("fs");
	property p_off; $rose(cs_n) |-> ##[1:6] !serial_result_oe; endproperty
	a_off: assert property (p_off) else $error("no release");
	property p_take; conv_valid && conv_ready |=> (!conv_ready) [*3]; endproperty
	a_take: assert property (p_take) else $error("conv");
	property p_hold; (serial_result_oe && !sclk) [*2] |-> $stable(serial_result_out); endproperty
	a_hold: assert property (p_hold) else $error("shift");
	property p_cnt; serial_result_oe |-> nf_q <= 5'd16; endproperty
	a_cnt: assert property (p_cnt) else $error("count");
	property p_end; $fell(serial_result_oe) && !cs_n |-> nf_q == 5'd16; endproperty
	a_end: assert property (p_end) else $error("length");
endmodule : asrp_props
bind asrp_top asrp_props chk_u (.clk, .srst, .conv_valid, .conv_ready, .powered_down, .cs_n, .sclk,
	.frame_sync_in, .serial_result_out, .serial_result_oe);

// ### tb/asrp_host.sv
`timescale 1ns/1ps
// -
// Host
// -
module asrp_host (
	// Link
	output logic      cs_n,
	output logic      sclk,
	output logic      fs,
	input  wire logic sd,
	input  wire logic oe
);
	logic [15:0] w;
	event        done;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		fs   = 1'b1;
	end
	task automatic frame(input logic use_fs, input int n);
		fs = !use_fs;
		#107 cs_n = 1'b0;
		if (use_fs) begin
			#200 fs = 1'b1;
			#200 fs = 1'b0;
		end
		#600;
		for (int i = 0; i < n; i++) begin
			sclk = 1'b1;
			#220 sclk = 1'b0;
			if (i < 16) w = {w[14:0], oe ? sd : 1'bx};
			#100;
		end
		#200 cs_n = 1'b1;
		fs = 1'b1;
		-> done;
		#200 sclk = 1'b1;
		#160 sclk = 1'b0;
	endtask : frame
endmodule : asrp_host

// ### tb/asrp_tb.sv
`timescale 1ns/1ps
// -
// Bench
// -
module asrp_tb;
	logic        clk = 1'b0, srst = 1'b1, conv_valid = 1'b0;
	logic [11:0] conv_code = 12'h000;
	logic        conv_ready, powered_down, cs_n, sclk, fs, sd, oe;
	logic [15:0] q[$];
	int          n_fail = 0, n_checks = 0, seed = 37670;
	always #20 clk = ~clk;
	asrp_top #(.CC(4)) dut_u (.clk, .srst, .conv_valid, .conv_code, .conv_ready, .powered_down, .cs_n, .sclk,
		.frame_sync_in(fs), .serial_result_out(sd), .serial_result_oe(oe));
	asrp_host host_u (.cs_n, .sclk, .fs, .sd, .oe);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict;
		if (n_fail == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	task automatic push(input logic [11:0] c);
		int   i = 0;
		logic r;
		@(posedge clk);
		#1 conv_code = c;
		conv_valid = 1'b1;
		r = conv_ready;
		@(posedge clk);
		while (r !== 1'b1 && i++ < 400) begin
			#1 r = conv_ready;
			@(posedge clk);
		end
		if (r !== 1'b1) n_fail++;
		q.push_back({c, 4'h0});
		#1 conv_valid = 1'b0;
	endtask : push
	always @(host_u.done) chk(host_u.w, (q.size() > 0) ? q.pop_front() : 16'h0000);
	initial begin
		#300us;
		n_fail++;
		give_verdict();
	end
	initial begin
		repeat (16) @(posedge clk);
		#1 srst = 1'b0;
		fork
			begin
				push(12'hfff);
				push(12'h000);
				repeat (3) push(12'($random(seed)));
			end
			begin
				#9us host_u.frame(1'b0, 20);
				repeat (5) host_u.frame(1'b0, 16);
			end
		join
		host_u.frame(1'b1, 16);
		give_verdict();
	end
endmodule : asrp_tb
